// *** gqsc_top.sv ***
// Notes on behaviour
// - The query reply carries the query code in byte 0.
// - The query reply carries zero in byte 1 to signal success.
// - Bytes 2,4,6,8 hold each pin's level as 0 or 1 when it is general I/O, else 0xEE.
// - Bytes 3,5,7,9 hold each pin's direction, 0 output and 1 input, else 0xEF.
// - Changed settings live only in volatile state and revert to power-up defaults on reset.
// - Bit 7 of settings byte 2 enables loading the clock divider and duty, else they hold.
// - Bits 2-0 of settings byte 2 are the divider, bits 6-5 are ignored.
// - Bit 7 of settings byte 3 enables loading the reference selection from bits 2-0.
// - Bits 2-1 of settings byte 3 set the reference module to off, 1.024, 2.048 or 4.096 V.
// - Bit 0 of settings byte 3 picks the reference module when one, the supply when zero.
// - Bit 7 of settings byte 4 enables loading a new converter value, else it holds.
// - Bits 4-0 of settings byte 4 are the five-bit converter value.
`timescale 1ns/1ps
`default_nettype none

module gqsc_top
	import gqsc_pkg::*;
(
	input  wire logic           i_clk_sys,
	input  wire logic           i_rst_n,
	input  wire logic           i_cmd_valid,
	input  wire logic [7:0]     i_cmd_byte,
	output logic                o_cmd_ready,
	input  wire gqsc_pin_t      i_general_pin_zero,
	input  wire gqsc_pin_t      i_general_pin_one,
	input  wire gqsc_pin_t      i_general_pin_two,
	input  wire gqsc_pin_t      i_general_pin_three,
	input  wire gqsc_settings_t i_pwrup_settings,
	output logic                o_rsp_valid,
	output logic [7:0]          o_rsp_byte,
	output logic                o_rsp_last,
	input  wire logic           i_rsp_ready,
	output gqsc_settings_t      o_settings,
	output logic                o_settings_load,
	output logic                o_cmd_ignored
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Only the release is synchronised; a stopped clock still resets at once
	logic [1:0] rst_sync_q;
	logic [1:0] rst_sync_d;
	logic       rst_n;

	always_comb begin
		rst_sync_d = {rst_sync_q[0], 1'b1};
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= rst_sync_d;
		end
	end

	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// Reply helpers
	// ----------------------------------------
	function automatic logic [7:0] pin_byte(
		input gqsc_pin_t pin,
		input logic      want_dir
	);
		logic [7:0] b;
		b = GQSC_BYTE_ZERO;
		if (!pin.is_gpio) begin
			b = want_dir ? GQSC_DIR_NOGPIO : GQSC_LEVEL_NOGPIO;
		end else if (want_dir) begin
			b = pin.dir_in ? GQSC_BYTE_ONE : GQSC_BYTE_ZERO;
		end else begin
			b = pin.level ? GQSC_BYTE_ONE : GQSC_BYTE_ZERO;
		end
		return b;
	endfunction

	// Indices past the pin block fall through to the fill value
	function automatic logic [7:0] rsp_byte(
		input logic [5:0]      idx,
		input gqsc_pin_t [3:0] snap
	);
		logic [7:0] b;
		logic [5:0] rel;
		rel = 6'(idx - GQSC_IDX_PIN_FIRST);
		b   = GQSC_FILL;
		if (idx == GQSC_IDX_OPCODE) begin
			b = GQSC_OP_QUERY;
		end else if (idx == GQSC_IDX_STATUS) begin
			b = GQSC_STATUS_OK;
		end else if (idx <= GQSC_IDX_PIN_LAST) begin
			b = pin_byte(snap[rel[2:1]], rel[0]);
		end
		return b;
	endfunction

	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	gqsc_state_t state_q;
	gqsc_state_t state_d;
	logic        init_done_q;
	logic        init_done_d;
	logic [5:0]  rx_idx_q;
	logic [5:0]  rx_idx_d;
	logic [7:0]  opcode_q;
	logic [7:0]  opcode_d;
	logic        ignored_q;
	logic        ignored_d;
	logic        accept;
	logic        rx_last;
	logic        rsp_done;
	logic [7:0]  op_now;

	// Ready drops while a reply drains; the host keeps its next byte
	assign o_cmd_ready = init_done_q && (state_q == GQSC_ST_RECV);
	assign accept      = i_cmd_valid && o_cmd_ready;
	assign rx_last     = accept && (rx_idx_q == GQSC_IDX_LAST);
	// Opcode byte is live in the cycle it arrives
	assign op_now = (rx_idx_q == GQSC_IDX_OPCODE) ? i_cmd_byte : opcode_q;

	always_comb begin
		state_d     = state_q;
		init_done_d = 1'b1;
		rx_idx_d    = rx_idx_q;
		opcode_d    = opcode_q;
		ignored_d   = 1'b0;
		unique case (state_q)
			GQSC_ST_RECV: begin
				if (accept) begin
					rx_idx_d = 6'(rx_idx_q + GQSC_IDX_STEP);
					if (rx_idx_q == GQSC_IDX_OPCODE) begin
						opcode_d = i_cmd_byte;
					end
				end
				// Reply only once the whole report is in, so framing stays aligned
				if (rx_last) begin
					if (op_now == GQSC_OP_QUERY) begin
						state_d = GQSC_ST_RESP;
					end else if (op_now != GQSC_OP_SETTINGS) begin
						// Unknown reports are still consumed whole so framing holds
						ignored_d = 1'b1;
					end
				end
			end
			GQSC_ST_RESP: begin
				if (rsp_done) begin
					state_d = GQSC_ST_RECV;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= GQSC_ST_RECV;
			init_done_q <= 1'b0;
			rx_idx_q    <= GQSC_IDX_OPCODE;
			opcode_q    <= GQSC_BYTE_ZERO;
			ignored_q   <= 1'b0;
		end else begin
			state_q     <= state_d;
			init_done_q <= init_done_d;
			rx_idx_q    <= rx_idx_d;
			opcode_q    <= opcode_d;
			ignored_q   <= ignored_d;
		end
	end

	assign o_cmd_ignored = ignored_q;

	// ----------------------------------------
	// Query reply
	// ----------------------------------------
	gqsc_pin_t [3:0] pins_now;
	gqsc_pin_t [3:0] snap_q;
	gqsc_pin_t [3:0] snap_d;
	logic [5:0]      rsp_idx_q;
	logic [5:0]      rsp_idx_d;
	logic [5:0]      rsp_nxt;
	logic [7:0]      rsp_data_q;
	logic [7:0]      rsp_data_d;
	logic            rsp_valid_q;
	logic            rsp_valid_d;
	logic            rsp_last_q;
	logic            rsp_last_d;
	logic            rsp_take;

	assign pins_now = {i_general_pin_three, i_general_pin_two,
		i_general_pin_one, i_general_pin_zero};
	assign rsp_take = rsp_valid_q && i_rsp_ready;
	assign rsp_done = rsp_take && rsp_last_q;
	// Look ahead one index so the next byte is ready as the take lands
	assign rsp_nxt  = 6'(rsp_idx_q + GQSC_IDX_STEP);

	always_comb begin
		snap_d      = snap_q;
		rsp_idx_d   = rsp_idx_q;
		rsp_data_d  = rsp_data_q;
		rsp_valid_d = rsp_valid_q;
		rsp_last_d  = rsp_last_q;
		if (rx_last && (op_now == GQSC_OP_QUERY)) begin
			// Snapshot keeps one reply coherent while pins move
			snap_d      = pins_now;
			rsp_idx_d   = GQSC_IDX_OPCODE;
			rsp_data_d  = rsp_byte(GQSC_IDX_OPCODE, pins_now);
			rsp_valid_d = 1'b1;
			rsp_last_d  = 1'b0;
		end else if (rsp_done) begin
			rsp_valid_d = 1'b0;
			rsp_last_d  = 1'b0;
		end else if (rsp_take) begin
			rsp_idx_d  = rsp_nxt;
			rsp_data_d = rsp_byte(rsp_nxt, snap_q);
			rsp_last_d = (rsp_nxt == GQSC_IDX_LAST);
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			snap_q      <= '0;
			rsp_idx_q   <= GQSC_IDX_OPCODE;
			rsp_data_q  <= GQSC_FILL;
			rsp_valid_q <= 1'b0;
			rsp_last_q  <= 1'b0;
		end else begin
			snap_q      <= snap_d;
			rsp_idx_q   <= rsp_idx_d;
			rsp_data_q  <= rsp_data_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_last_q  <= rsp_last_d;
		end
	end

	assign o_rsp_valid = rsp_valid_q;
	assign o_rsp_byte  = rsp_data_q;
	assign o_rsp_last  = rsp_last_q;

	// ----------------------------------------
	// Run-time settings
	// ----------------------------------------
	gqsc_settings_t set_q;
	gqsc_settings_t set_d;
	logic           load_q;
	logic           load_d;
	logic           is_set;
	logic           ld_en;

	// Byte 1 and opcode byte can reach the decode below but fall to its default arm and load nothing
	assign is_set = accept && (opcode_q == GQSC_OP_SETTINGS);
	// Fields apply byte by byte as they arrive, not at the end of the report
	assign ld_en  = i_cmd_byte[GQSC_LOAD_BIT];

	always_comb begin
		set_d  = set_q;
		load_d = 1'b0;
		if (!init_done_q) begin
			// Defaults come back after every reset; nothing here writes them
			set_d = i_pwrup_settings;
		end else if (is_set && ld_en) begin
			load_d = 1'b1;
			unique case (rx_idx_q)
				GQSC_IDX_CLK: begin
					set_d.duty    = gqsc_duty_t'(i_cmd_byte[4:3]);
					set_d.clk_div = i_cmd_byte[2:0];
				end
				GQSC_IDX_REF: begin
					set_d.irm_level = gqsc_irm_level_t'(i_cmd_byte[2:1]);
					set_d.ref_src   = gqsc_ref_src_t'(i_cmd_byte[0]);
				end
				GQSC_IDX_DAC: begin
					set_d.dac_val = i_cmd_byte[4:0];
				end
				default: begin
					load_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			set_q  <= GQSC_SETTINGS_RST;
			load_q <= 1'b0;
		end else begin
			set_q  <= set_d;
			load_q <= load_d;
		end
	end

	assign o_settings      = set_q;
	assign o_settings_load = load_q;

endmodule

`default_nettype wire

// *** gqsc_pkg.sv ***
package gqsc_pkg;

	// ----------------------------------------
	// Command codes and response values
	// ----------------------------------------
	localparam logic [7:0] GQSC_OP_QUERY     = 8'h51;
	localparam logic [7:0] GQSC_OP_SETTINGS  = 8'h60;
	localparam logic [7:0] GQSC_STATUS_OK    = 8'h00;
	localparam logic [7:0] GQSC_LEVEL_NOGPIO = 8'hEE;
	localparam logic [7:0] GQSC_DIR_NOGPIO   = 8'hEF;
	localparam logic [7:0] GQSC_BYTE_ZERO    = 8'h00;
	localparam logic [7:0] GQSC_BYTE_ONE     = 8'h01;
	localparam logic [7:0] GQSC_FILL         = 8'h00;

	// ----------------------------------------
	// Report layout
	// ----------------------------------------
	localparam logic [5:0] GQSC_IDX_OPCODE    = 6'h00;
	localparam logic [5:0] GQSC_IDX_STATUS    = 6'h01;
	localparam logic [5:0] GQSC_IDX_PIN_FIRST = 6'h02;
	localparam logic [5:0] GQSC_IDX_PIN_LAST  = 6'h09;
	localparam logic [5:0] GQSC_IDX_CLK       = 6'h02;
	localparam logic [5:0] GQSC_IDX_REF       = 6'h03;
	localparam logic [5:0] GQSC_IDX_DAC       = 6'h04;
	localparam logic [5:0] GQSC_IDX_LAST      = 6'h3F;
	localparam logic [5:0] GQSC_IDX_STEP      = 6'h01;
	localparam int         GQSC_LOAD_BIT      = 7;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		GQSC_DUTY_0  = 2'b00,
		GQSC_DUTY_25 = 2'b01,
		GQSC_DUTY_50 = 2'b10,
		GQSC_DUTY_75 = 2'b11
	} gqsc_duty_t;

	typedef enum logic [1:0] {
		GQSC_IRM_OFF  = 2'b00,
		GQSC_IRM_1024 = 2'b01,
		GQSC_IRM_2048 = 2'b10,
		GQSC_IRM_4096 = 2'b11
	} gqsc_irm_level_t;

	typedef enum logic {
		GQSC_REF_SUPPLY = 1'b0,
		GQSC_REF_IRM    = 1'b1
	} gqsc_ref_src_t;

	typedef enum logic {
		GQSC_ST_RECV = 1'b0,
		GQSC_ST_RESP = 1'b1
	} gqsc_state_t;

	typedef struct packed {
		logic is_gpio;
		logic dir_in;
		logic level;
	} gqsc_pin_t;

	typedef struct packed {
		logic [2:0]      clk_div;
		gqsc_duty_t      duty;
		gqsc_irm_level_t irm_level;
		gqsc_ref_src_t   ref_src;
		logic [4:0]      dac_val;
	} gqsc_settings_t;

	localparam gqsc_settings_t GQSC_SETTINGS_RST = '{
		clk_div:   3'h0,
		duty:      GQSC_DUTY_0,
		irm_level: GQSC_IRM_OFF,
		ref_src:   GQSC_REF_SUPPLY,
		dac_val:   5'h00
	};

endpackage

// *** gqsc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module gqsc_monitor
	import gqsc_pkg::*;
(
	input wire logic           i_clk_sys,
	input wire logic           i_rst_n,
	input wire logic           i_cmd_valid,
	input wire logic [7:0]     i_cmd_byte,
	input wire logic           o_cmd_ready,
	input wire logic           o_rsp_valid,
	input wire logic [7:0]     o_rsp_byte,
	input wire logic           o_rsp_last,
	input wire logic           i_rsp_ready,
	input wire gqsc_settings_t o_settings,
	input wire logic           o_settings_load
);
	// ----------------------------------------
	// Byte indices seen at the ports
	// ----------------------------------------
	logic [5:0] ci_q;
	logic [5:0] ri_q;
	logic [7:0] op_q;
	logic [2:0] age_q;
	wire        take = i_cmd_valid && o_cmd_ready;
	wire        sb   = take && op_q == GQSC_OP_SETTINGS && i_cmd_byte[7];
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ci_q  <= 6'h00;
			ri_q  <= 6'h00;
			op_q  <= 8'h00;
			age_q <= 3'h0;
		end else begin
			ci_q  <= ci_q + 6'(take);
			ri_q  <= ri_q + 6'(o_rsp_valid && i_rsp_ready);
			op_q  <= (take && ci_q == 6'h00) ? i_cmd_byte : op_q;
			age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_clk;
		sb && ci_q == 6'h02 |=> o_settings_load && o_settings.clk_div == $past(i_cmd_byte[2:0])
			&& o_settings.duty == $past(i_cmd_byte[4:3]);
	endproperty
	a_clk: assert property (p_clk) else $error("clock field not loaded");
	property p_ref;
		sb && ci_q == 6'h03 |=> o_settings.irm_level == $past(i_cmd_byte[2:1])
			&& o_settings.ref_src == $past(i_cmd_byte[0]);
	endproperty
	a_ref: assert property (p_ref) else $error("reference not loaded");
	property p_dac;
		sb && ci_q == 6'h04 |=> o_settings.dac_val == $past(i_cmd_byte[4:0]);
	endproperty
	a_dac: assert property (p_dac) else $error("converter value not loaded");
	// Power-up load happens a few cycles after release without a pulse
	property p_keep;
		age_q == 3'h7 && !o_settings_load |-> $stable(o_settings);
	endproperty
	a_keep: assert property (p_keep) else $error("settings moved without load");
	property p_op;
		o_rsp_valid && ri_q == 6'h00 |-> o_rsp_byte == GQSC_OP_QUERY;
	endproperty
	a_op: assert property (p_op) else $error("reply byte 0 wrong");
	property p_ok;
		o_rsp_valid && ri_q == 6'h01 |-> o_rsp_byte == GQSC_STATUS_OK;
	endproperty
	a_ok: assert property (p_ok) else $error("reply status wrong");
	property p_lvl;
		o_rsp_valid && ri_q inside {[6'h02:6'h09]} && !ri_q[0] |-> o_rsp_byte inside {8'h00, 8'h01, 8'hEE};
	endproperty
	a_lvl: assert property (p_lvl) else $error("level byte out of range");
	property p_dir;
		o_rsp_valid && ri_q inside {[6'h02:6'h09]} && ri_q[0] |-> o_rsp_byte inside {8'h00, 8'h01, 8'hEF};
	endproperty
	a_dir: assert property (p_dir) else $error("direction byte out of range");
	property p_last;
		o_rsp_valid |-> o_rsp_last == (ri_q == 6'h3F);
	endproperty
	a_last: assert property (p_last) else $error("last flag misplaced");
	property p_hold;
		o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte);
	endproperty
	a_hold: assert property (p_hold) else $error("reply byte dropped while stalled");
	c_load: cover property (sb && ci_q == 6'h02);
	c_end: cover property (o_rsp_last && i_rsp_ready);
	c_skip: cover property (take && ci_q == 6'h04 && !i_cmd_byte[7]);
endmodule
bind gqsc_top gqsc_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte), .o_cmd_ready(o_cmd_ready),
	.o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte), .o_rsp_last(o_rsp_last),
	.i_rsp_ready(i_rsp_ready), .o_settings(o_settings), .o_settings_load(o_settings_load));
`default_nettype wire

// *** gqsc_host_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module gqsc_host_sink (
	input  wire logic       i_clk_sys,
	input  wire logic       i_valid,
	input  wire logic [7:0] i_byte,
	input  wire logic       i_slow,
	output logic            o_ready,
	output logic [7:0]      o_rx [64],
	output int              o_n
);
	// Host may stall every other cycle; the device must hold its byte
	initial o_ready = 1'b0;
	initial o_n = 0;
	always @(posedge i_clk_sys) begin
		if (i_valid && o_ready) begin
			o_rx[o_n % 64] = i_byte;
			o_n = o_n + 1;
		end
		#1 o_ready = i_slow ? !o_ready : 1'b1;
	end
endmodule
`default_nettype wire

// *** gpio_query_sram_settings_cmd_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_query_sram_settings_cmd_tb;
	import gqsc_pkg::*;
	logic           clk = 1'b0;
	logic           rst_n = 1'b0;
	logic           cv = 1'b0;
	logic [7:0]     cb = 8'h00;
	logic           slow = 1'b1;
	logic           cr, rv, rl, rr, ld, ign;
	logic [7:0]     rb;
	logic [7:0]     ev, b2, b3, b4;
	logic [7:0]     rx [64];
	gqsc_pin_t      pins [4];
	gqsc_pin_t      pa [4] = '{3'b111, 3'b100, 3'b011, 3'b101};
	gqsc_settings_t pwr = '{3'h5, GQSC_DUTY_50, GQSC_IRM_1024, GQSC_REF_IRM, 5'h0A};
	gqsc_settings_t st, ex;
	int             n, failures = 0, cmp_count = 0, cyc = 0, ign_n = 0;
	gqsc_top DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cmd_valid(cv), .i_cmd_byte(cb),
		.o_cmd_ready(cr), .i_general_pin_zero(pins[0]), .i_general_pin_one(pins[1]),
		.i_general_pin_two(pins[2]), .i_general_pin_three(pins[3]), .i_pwrup_settings(pwr),
		.o_rsp_valid(rv), .o_rsp_byte(rb), .o_rsp_last(rl), .i_rsp_ready(rr),
		.o_settings(st), .o_settings_load(ld), .o_cmd_ignored(ign));
	gqsc_host_sink u_host (.i_clk_sys(clk), .i_valid(rv), .i_byte(rb), .i_slow(slow),
		.o_ready(rr), .o_rx(rx), .o_n(n));
	initial forever #5 clk = ~clk;
	// Ceiling well above the several hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (ign === 1'b1) ign_n++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task wrap_up;
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task send(input logic [7:0] b);
		cb = b;
		cv = 1'b1;
		while (cr !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
	endtask
	// Filler bytes are non-zero so an ignored byte that leaks would show
	task report(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
		for (int i = 0; i < 64; i++) begin
			send(i == 0 ? op : i == 1 ? 8'hA5 : i == 2 ? b2 : i == 3 ? b3 : i == 4 ? b4 : 8'hFF);
		end
		cv = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task do_reset;
		#1 rst_n = 1'b0;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask
	function automatic logic [7:0] code(gqsc_pin_t p, logic d);
		if (!p.is_gpio) return d ? 8'hEF : 8'hEE;
		return {7'h00, d ? p.dir_in : p.level};
	endfunction
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		pins = pa;
		do_reset();
		chk("pwrup", {3'h0, st}, {3'h0, pwr});
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 4; k++) pins[k] = p ? ~pa[k] : pa[k];
			slow = (p == 0);
			report(GQSC_OP_QUERY, 8'h00, 8'h00, 8'h00);
			while (n < 64 * (p + 1)) @(posedge clk);
			#1;
			for (int i = 0; i < 64; i++) begin
				ev = (i < 2) ? (i == 0 ? GQSC_OP_QUERY : GQSC_STATUS_OK) : 8'h00;
				if (i >= 2 && i < 10) ev = code(pins[(i - 2) / 2], i[0]);
				chk("reply", {8'h00, rx[i]}, {8'h00, ev});
			end
		end
		for (logic [2:0] d = 0; d < 4; d++) begin
			b2 = {3'b111, d[1:0], d[0], d[1:0]};
			b3 = {5'h1F, d[1:0], d[0]};
			b4 = {3'b111, d[1:0], 3'h5};
			report(GQSC_OP_SETTINGS, b2, b3, b4);
			ex = '{{d[0], d[1:0]}, gqsc_duty_t'(d[1:0]), gqsc_irm_level_t'(d[1:0]),
				gqsc_ref_src_t'(d[0]), {d[1:0], 3'h5}};
			chk("settings", {3'h0, st}, {3'h0, ex});
		end
		report(GQSC_OP_SETTINGS, 8'h7F, 8'h7F, 8'h7F);
		chk("no_load", {3'h0, st}, {3'h0, ex});
		report(8'h33, 8'hFF, 8'hFF, 8'hFF);
		repeat (2) @(posedge clk);
		#1;
		chk("ignored", 16'(ign_n), 16'h0001);
		do_reset();
		chk("reset", {3'h0, st}, {3'h0, pwr});
		wrap_up();
	end
endmodule
`default_nettype wire
